// >>> shared/ists_defs.svh
`ifndef ISTS_DEFS_SVH
`define ISTS_DEFS_SVH

// Configuration dword addresses (byte index of each dword)
`define ISTS_OFS_SETUP     8'h48
`define ISTS_OFS_STROBE16  8'h4c
`define ISTS_OFS_BYTECMD   8'h50

// Byte indices of the 8-bit registers and the 4-bit ready sync field inside their dwords
`define ISTS_OFS_MRD       8'h4c
`define ISTS_OFS_MWR       8'h4d
`define ISTS_OFS_SRD       8'h4e
`define ISTS_OFS_SWR       8'h4f
`define ISTS_OFS_MBYTE     8'h50
`define ISTS_OFS_SBYTE     8'h51
`define ISTS_OFS_RSYNC     8'h52

// Field positions
`define ISTS_HI_MSB        7
`define ISTS_HI_LSB        4
`define ISTS_LO_MSB        3
`define ISTS_LO_LSB        0
`define ISTS_RDSYNC_MSB    3
`define ISTS_RDSYNC_LSB    2
`define ISTS_WRSYNC_MSB    1
`define ISTS_WRSYNC_LSB    0

// Reset values
`define ISTS_RST_SETUP     8'h33
`define ISTS_RST_RD16      8'h33
`define ISTS_RST_WR16      8'h6e
`define ISTS_RST_BYTE      8'haa
`define ISTS_RST_RSYNC     4'h5

`endif

// >>> shared/ists_pkg.sv
package ists_pkg;

  // Transfer sequencer states, one-hot
  typedef enum logic [3:0] {
    ISTS_IDLE  = 4'b0001,
    ISTS_SETUP = 4'b0010,
    ISTS_STRB  = 4'b0100,
    ISTS_RECOV = 4'b1000
  } ists_state_t;

endpackage

// >>> hdl/ists_ready_sync.sv
// Two-flop synchroniser with a programmable extra delay on the rising edge
module ists_ready_sync (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       raw_in,
  input  wire logic [1:0] extra_sel,
  output logic            ready_out
);
  logic       meta_r;
  logic       sync_r;
  logic [1:0] hold_r;

  // Metastability guard
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
    end
  end

  // Falling edge passes at once, rising edge waits extra_sel clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r    <= 2'h0;
      ready_out <= 1'b0;
    end else if (!sync_r) begin
      hold_r    <= 2'h0;
      ready_out <= 1'b0;
    end else if (hold_r >= extra_sel) begin
      ready_out <= 1'b1;
    end else begin
      hold_r <= hold_r + 2'h1;
    end
  end
endmodule

// >>> hdl/ists_timing.sv
// What this block does
// - Master address setup lasts setup nibble 3:0 plus one clocks; resets 0011.
// - Slave address setup lasts setup nibble 7:4 plus one clocks; resets 0011.
// - Master 16-bit read strobe width is upper nibble plus one; resets 0011.
// - Master 16-bit read recovery is lower nibble plus one; resets 0011.
// - Master 16-bit write strobe width is upper nibble plus one; resets 0110.
// - Master 16-bit write recovery is lower nibble plus one; resets 1110.
// - Slave 16-bit read strobe width is upper nibble plus one; resets 0011.
// - Slave 16-bit read recovery is lower nibble plus one; resets 0011.
// - Slave 16-bit write strobe width is upper nibble plus one; resets 0110.
// - Slave 16-bit write recovery is lower nibble plus one; resets 1110.
// - Master 8-bit command strobe width is upper nibble plus one; resets 1010.
// - Master 8-bit command recovery is lower nibble plus one; resets 1010.
// - Slave 8-bit command strobe width is upper nibble plus one; resets 1010.
// - Slave 8-bit command recovery is lower nibble plus one; resets 1010.
// - The 8-bit timing set serves drives in transfer modes 0, 1, 2.
// - Ready rising edge during reads is synchronised by field 3:2; resets 01.
// - Ready rising edge during writes is synchronised by field 1:0; resets 01.
`include "ists_defs.svh"

module ists_timing (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_slave,
  input  wire logic        req_byte,
  output logic             req_ready,
  output logic             xfer_done,
  output logic             drive_addr_valid,
  output logic             drive_slave_sel,
  output logic             drive_read_strobe_n,
  output logic             drive_write_strobe_n,
  input  wire logic        drive_wait_ready
);
  logic [7:0]          setup_r;
  logic [7:0]          mrd_r;
  logic [7:0]          mwr_r;
  logic [7:0]          srd_r;
  logic [7:0]          swr_r;
  logic [7:0]          mbyte_r;
  logic [7:0]          sbyte_r;
  logic [3:0]          rsync_r;
  ists_pkg::ists_state_t state_r;
  ists_pkg::ists_state_t state_nxt;
  logic [3:0]          cnt_r;
  logic [3:0]          pw_r;
  logic [3:0]          rc_r;
  logic [3:0]          su_r;
  logic                wr_r;
  logic [7:0]          tim_sel;
  logic [3:0]          su_sel;
  logic [1:0]          sync_sel;
  logic                rdy_sync;
  logic                accept;
  logic                cnt_zero;

  assign accept   = (state_r == ists_pkg::ISTS_IDLE) && req_valid;
  assign cnt_zero = (cnt_r == 4'h0);

  // Configuration writes, byte lanes by cfg_be
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_r <= `ISTS_RST_SETUP;
      mrd_r   <= `ISTS_RST_RD16;
      mwr_r   <= `ISTS_RST_WR16;
      srd_r   <= `ISTS_RST_RD16;
      swr_r   <= `ISTS_RST_WR16;
      mbyte_r <= `ISTS_RST_BYTE;
      sbyte_r <= `ISTS_RST_BYTE;
      rsync_r <= `ISTS_RST_RSYNC;
    end else if (cfg_wr) begin
      unique case ({cfg_addr[7:2], 2'b00})
        `ISTS_OFS_SETUP: begin
          if (cfg_be[0]) setup_r <= cfg_wdata[7:0];
        end
        `ISTS_OFS_STROBE16: begin
          if (cfg_be[0]) mrd_r <= cfg_wdata[7:0];
          if (cfg_be[1]) mwr_r <= cfg_wdata[15:8];
          if (cfg_be[2]) srd_r <= cfg_wdata[23:16];
          if (cfg_be[3]) swr_r <= cfg_wdata[31:24];
        end
        `ISTS_OFS_BYTECMD: begin
          if (cfg_be[0]) mbyte_r <= cfg_wdata[7:0];
          if (cfg_be[1]) sbyte_r <= cfg_wdata[15:8];
          if (cfg_be[2]) rsync_r <= cfg_wdata[19:16];
        end
        default: ;
      endcase
    end
  end

  // Configuration reads, registered; reserved and unmapped read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 32'h0;
    end else if (cfg_rd) begin
      unique case ({cfg_addr[7:2], 2'b00})
        `ISTS_OFS_SETUP:    cfg_rdata <= {24'h0, setup_r};
        `ISTS_OFS_STROBE16: cfg_rdata <= {swr_r, srd_r, mwr_r, mrd_r};
        `ISTS_OFS_BYTECMD:  cfg_rdata <= {12'h0, rsync_r, sbyte_r, mbyte_r};
        default:            cfg_rdata <= 32'h0;
      endcase
    end
  end

  // Timing set chosen by drive and width
  always_comb begin
    tim_sel = 8'h0;
    su_sel  = 4'h0;
    if (req_byte) begin
      tim_sel = req_slave ? sbyte_r : mbyte_r;
    end else if (req_slave) begin
      tim_sel = req_write ? swr_r : srd_r;
    end else begin
      tim_sel = req_write ? mwr_r : mrd_r;
    end
    if (req_slave) begin
      su_sel = setup_r[`ISTS_HI_MSB:`ISTS_HI_LSB];
    end else begin
      su_sel = setup_r[`ISTS_LO_MSB:`ISTS_LO_LSB];
    end
  end

  // Sync depth follows the latched direction
  always_comb begin
    if (wr_r) begin
      sync_sel = rsync_r[`ISTS_WRSYNC_MSB:`ISTS_WRSYNC_LSB];
    end else begin
      sync_sel = rsync_r[`ISTS_RDSYNC_MSB:`ISTS_RDSYNC_LSB];
    end
  end

  ists_ready_sync u_rdy (
    .clk       (clk),
    .rst_n     (rst_n),
    .raw_in    (drive_wait_ready),
    .extra_sel (sync_sel),
    .ready_out (rdy_sync)
  );

  // Latch the timing of the accepted transfer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pw_r <= 4'h0;
      rc_r <= 4'h0;
      su_r <= 4'h0;
      wr_r <= 1'b0;
      drive_slave_sel <= 1'b0;
    end else if (accept) begin
      pw_r <= tim_sel[`ISTS_HI_MSB:`ISTS_HI_LSB];
      rc_r <= tim_sel[`ISTS_LO_MSB:`ISTS_LO_LSB];
      su_r <= su_sel;
      wr_r <= req_write;
      drive_slave_sel <= req_slave;
    end
  end

  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ists_pkg::ISTS_IDLE: begin
        if (req_valid) state_nxt = ists_pkg::ISTS_SETUP;
      end
      ists_pkg::ISTS_SETUP: begin
        if (cnt_zero) state_nxt = ists_pkg::ISTS_STRB;
      end
      ists_pkg::ISTS_STRB: begin
        if (cnt_zero && rdy_sync) state_nxt = ists_pkg::ISTS_RECOV;
      end
      ists_pkg::ISTS_RECOV: begin
        if (cnt_zero) state_nxt = ists_pkg::ISTS_IDLE;
      end
      default: state_nxt = ists_pkg::ISTS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ists_pkg::ISTS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Phase counter: loaded with field value, so phase lasts value plus one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
    end else if (accept) begin
      cnt_r <= su_sel;
    end else if (state_r == ists_pkg::ISTS_SETUP && cnt_zero) begin
      cnt_r <= pw_r;
    end else if (state_r == ists_pkg::ISTS_STRB && cnt_zero && rdy_sync) begin
      cnt_r <= rc_r;
    end else if (!cnt_zero) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // Pin outputs, all from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_addr_valid     <= 1'b0;
      drive_read_strobe_n  <= 1'b1;
      drive_write_strobe_n <= 1'b1;
      xfer_done            <= 1'b0;
      req_ready            <= 1'b0;
    end else begin
      drive_addr_valid <= (state_nxt == ists_pkg::ISTS_SETUP) ||
                          (state_nxt == ists_pkg::ISTS_STRB);
      drive_read_strobe_n  <= !((state_nxt == ists_pkg::ISTS_STRB) && !wr_r);
      drive_write_strobe_n <= !((state_nxt == ists_pkg::ISTS_STRB) && wr_r);
      xfer_done <= (state_r == ists_pkg::ISTS_STRB) &&
                   (state_nxt == ists_pkg::ISTS_RECOV);
      req_ready <= (state_nxt == ists_pkg::ISTS_IDLE);
    end
  end

  // Helper: cycles spent in the current state
  logic [7:0] st_cyc_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_cyc_r <= 8'h0;
    end else if (state_nxt != state_r) begin
      st_cyc_r <= 8'h0;
    end else if (st_cyc_r != 8'hff) begin
      st_cyc_r <= st_cyc_r + 8'h1;
    end
  end

  logic strb_on;
  assign strb_on = !drive_read_strobe_n || !drive_write_strobe_n;

  sequence s_leave_setup;
    state_r == ists_pkg::ISTS_SETUP && state_nxt == ists_pkg::ISTS_STRB;
  endsequence

  sequence s_leave_strobe;
    state_r == ists_pkg::ISTS_STRB && state_nxt == ists_pkg::ISTS_RECOV;
  endsequence

  sequence s_leave_recov;
    state_r == ists_pkg::ISTS_RECOV && state_nxt == ists_pkg::ISTS_IDLE;
  endsequence

  a_setup_len: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_leave_setup |-> st_cyc_r == {4'h0, su_r})
    else $error("address setup length wrong");

  a_setup_pin: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_leave_setup |=> drive_addr_valid && strb_on && $past(drive_addr_valid) && !$past(strb_on))
    else $error("strobe did not follow setup");

  a_pulse_len: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_leave_strobe |-> st_cyc_r >= {4'h0, pw_r})
    else $error("strobe pulse too short");

  a_recov_len: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_leave_recov |-> st_cyc_r == {4'h0, rc_r})
    else $error("recovery length wrong");

  a_wait_extend: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_r == ists_pkg::ISTS_STRB && !rdy_sync) |=> strb_on)
    else $error("strobe released while not ready");

  a_strobe_dir: assert property (
    @(posedge clk) disable iff (!rst_n)
    strb_on |-> (drive_write_strobe_n != drive_read_strobe_n) && (wr_r == !drive_write_strobe_n))
    else $error("strobe direction wrong");

  a_recov_quiet: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_leave_strobe |=> !strb_on [*1] ##0 !drive_addr_valid)
    else $error("strobe not released at recovery");

  a_done_once: assert property (
    @(posedge clk) disable iff (!rst_n)
    xfer_done |-> $past(strb_on) && $past(rdy_sync) ##1 !xfer_done)
    else $error("done pulse not tied to release");

  a_ready_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    (req_ready && req_valid) |=> drive_addr_valid && !strb_on && !req_ready)
    else $error("accept did not start setup");
endmodule

// >>> test/ists_drive_model.sv
// Drive on the far side: asserts wait at each strobe fall for a chosen count
module ists_drive_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [3:0] slow_cycles,
  output logic            wait_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hold_r;
  logic       busy_r;

  // Wait count loads on the first strobe cycle; pulled up when idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 4'h0;
      busy_r <= 1'b0;
    end else begin
      busy_r <= !(read_strobe_n && write_strobe_n);
      if (!(read_strobe_n && write_strobe_n) && !busy_r) begin
        hold_r <= slow_cycles;
      end else if (hold_r != 4'h0) begin
        hold_r <= hold_r - 4'h1;
      end
    end
  end
  assign wait_ready = (hold_r == 4'h0);
endmodule

// >>> test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, cfg_wr, cfg_rd, req_valid, req_write, req_slave, req_byte;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be, slow_cycles;
  logic [31:0] cfg_wdata, cfg_rdata, sh48, sh4c, sh50, seed, d;
  logic        req_ready, xfer_done, addr_valid, slave_sel, rd_n, wr_n, wait_ready;
  int          mismatches, check_count, su, pw, rc;

  ists_timing ists_timing_i (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .req_valid(req_valid),
    .req_write(req_write), .req_slave(req_slave), .req_byte(req_byte), .req_ready(req_ready),
    .xfer_done(xfer_done), .drive_addr_valid(addr_valid), .drive_slave_sel(slave_sel),
    .drive_read_strobe_n(rd_n), .drive_write_strobe_n(wr_n), .drive_wait_ready(wait_ready));
  ists_drive_model ists_drive_model_i (.clk(clk), .rst_n(rst_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .slow_cycles(slow_cycles), .wait_ready(wait_ready));

  // Clock source
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  // Timing byte of the set that a transfer selects
  function automatic logic [7:0] tbyte(input logic w, input logic s, input logic b);
    logic [1:0] k;
    k = {s, w};
    if (b) return s ? sh50[15:8] : sh50[7:0];
    return sh4c[k*8 +: 8];
  endfunction

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Register write, shadow follows lanes and implemented bits
  task cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    @(posedge clk);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, be, v};
    @(posedge clk);
    cfg_wr <= 1'b0;
    if (a == 8'h48) sh48 = ((sh48 & ~m) | (v & m)) & 32'h0000_00ff;
    if (a == 8'h4c) sh4c = (sh4c & ~m) | (v & m);
    if (a == 8'h50) sh50 = ((sh50 & ~m) | (v & m)) & 32'h000f_ffff;
  endtask

  task cfg_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    {cfg_rd, cfg_addr} <= {1'b1, a};
    @(posedge clk);
    cfg_rd <= 1'b0;
    @(negedge clk);
    check("cfg_rdata", cfg_rdata, exp);
  endtask

  // One transfer, measuring setup, pulse and recovery in cycles
  task xfer(input logic w, input logic s, input logic b, input logic [3:0] k);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    {req_valid, req_write, req_slave, req_byte} <= {1'b1, w, s, b};
    slow_cycles <= k;
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    su = 0;
    pw = 0;
    rc = 0;
    while ((w ? wr_n : rd_n) === 1'b1 && n < 300) begin
      su++;
      n++;
      @(negedge clk);
    end
    check("drive_slave_sel", slave_sel, s);
    check("unused_strobe", w ? rd_n : wr_n, 1'b1);
    while ((w ? wr_n : rd_n) === 1'b0 && n < 300) begin
      pw++;
      n++;
      @(negedge clk);
    end
    check("xfer_done", xfer_done, 1'b1);
    check("addr_valid_end", addr_valid, 1'b0);
    while (req_ready !== 1'b1 && n < 300) begin
      rc++;
      n++;
      @(negedge clk);
    end
    if (n >= 300) begin
      mismatches++;
      $display("mismatch transfer_wait expected done seen timeout");
      print_verdict;
    end
  endtask

  task run(input logic w, input logic s, input logic b);
    logic [7:0] t;
    t = tbyte(w, s, b);
    xfer(w, s, b, 4'h0);
    check("setup_cycles", su, (s ? sh48[7:4] : sh48[3:0]) + 1);
    check("pulse_cycles", pw, t[7:4] + 1);
    check("recovery_cycles", rc, t[3:0] + 1);
  endtask

  // Main sequence
  initial begin
    {cfg_wr, cfg_rd, req_valid, req_write, req_slave, req_byte} = '0;
    {cfg_addr, cfg_be, cfg_wdata, slow_cycles} = '0;
    rst_n = 1'b0;
    seed = 32'h889cde90;
    mismatches = 0;
    check_count = 0;
    {sh48, sh4c, sh50} = {32'h33, 32'h6e336e33, 32'h0005aaaa};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    cfg_check(8'h48, sh48);
    cfg_check(8'h4c, sh4c);
    cfg_check(8'h50, sh50);
    cfg_check(8'h44, 32'h0);
    for (int i = 0; i < 8; i++) run(i[0], i[1], i[2]);
    $display("test reset_timing done");
    // Extreme field values, all zero then all ones
    for (int j = 0; j < 2; j++) begin
      d = j ? '1 : '0;
      cfg_write(8'h48, 4'hf, d);
      cfg_write(8'h4c, 4'hf, d);
      cfg_write(8'h50, 4'hf, d);
      cfg_check(8'h50, sh50);
      for (int i = 0; i < 8; i++) run(i[0], i[1], i[2]);
    end
    $display("test corner_timing done");
    // Random settings with partial lanes, then random transfers
    repeat (8) begin
      seed = xs(seed);
      cfg_write(8'h48, seed[31:28], seed);
      seed = xs(seed);
      cfg_write(8'h4c, seed[31:28], seed);
      seed = xs(seed);
      cfg_write(8'h50, seed[31:28], seed);
      cfg_check(8'h48, sh48);
      cfg_check(8'h4c, sh4c);
      cfg_check(8'h50, sh50);
      repeat (3) begin
        seed = xs(seed);
        run(seed[0], seed[1], seed[2]);
      end
    end
    $display("test random_timing done");
    // Fast-mode drive: byte sets copied from the read sets
    cfg_write(8'h50, 4'h3, {16'h0, sh4c[23:16], sh4c[7:0]});
    run(1'b0, 1'b0, 1'b1);
    run(1'b0, 1'b1, 1'b1);
    $display("test equal_sets done");
    // Drive holding wait for eight cycles, read sync 3, write sync 1
    // Pulse nibble 5 outlasts the ready synchroniser, so the wait is seen
    cfg_write(8'h4c, 4'hf, 32'h51515151);
    cfg_write(8'h50, 4'h4, 32'h000d0000);
    xfer(1'b0, 1'b0, 1'b0, 4'h8);
    check("read_wait_pulse", pw >= 13 && pw <= 17, 1'b1);
    xfer(1'b1, 1'b1, 1'b0, 4'h8);
    check("write_wait_pulse", pw >= 11 && pw <= 15, 1'b1);
    $display("test wait_extend done");
    // Reset in mid-run brings back the default timings
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check("reset_outputs", {req_ready, rd_n, wr_n, addr_valid, xfer_done}, 5'h0c);
    rst_n <= 1'b1;
    {sh48, sh4c, sh50} = {32'h33, 32'h6e336e33, 32'h0005aaaa};
    repeat (2) @(posedge clk);
    cfg_check(8'h48, sh48);
    cfg_check(8'h4c, sh4c);
    cfg_check(8'h50, sh50);
    run(1'b1, 1'b0, 1'b0);
    $display("test mid_reset done");
    print_verdict;
  end
endmodule
